// File: design/pmtr_pkg.sv
// Constants and types for the program memory table read block.
// Assumes a 40 MHz system clock and a core that issues one request at a time.
package pmtr_pkg;
    localparam int           PMTR_AW          = 12;
    localparam int           PMTR_DW          = 16;
    localparam int           PMTR_DEPTH       = 4096;
    localparam logic [11:0]  PMTR_RESET_VEC   = 12'h000;
    localparam logic [11:0]  PMTR_LAST_PAGE   = 12'hF00;
    localparam logic [7:0]   PMTR_LATCH_RST   = 8'h00;
    localparam logic [15:0]  PMTR_WORD_RST    = 16'h0000;
    localparam logic [1:0]   PMTR_SECTOR0     = 2'h0;

    typedef logic [11:0] pmtr_addr_t;
    typedef logic [15:0] pmtr_word_t;
    typedef logic [7:0]  pmtr_byte_t;

    // Table read flavours
    typedef enum logic [1:0] {
        PMTR_TR_PAGED,
        PMTR_TR_LASTPAGE,
        PMTR_TR_EXT_PAGED,
        PMTR_TR_EXT_LASTPAGE
    } pmtr_op_e;

    typedef enum logic [1:0] {
        PMTR_ST_RESET,
        PMTR_ST_IDLE,
        PMTR_ST_READ,
        PMTR_ST_XFER
    } pmtr_state_e;
endpackage

// File: design/pmtr_store.sv
// Program word store, flip-flop array with a registered read port.
// Assumes contents are loaded by the programming engine one word at a time.
module pmtr_store
    import pmtr_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // Load port
    input  wire logic               wr_en,
    input  wire pmtr_pkg::pmtr_addr_t wr_addr,
    input  wire pmtr_pkg::pmtr_word_t wr_data,
    // Read port
    input  wire logic               rd_en,
    input  wire pmtr_pkg::pmtr_addr_t rd_addr,
    output logic [15:0]             rd_data
);
    pmtr_word_t mem_q [PMTR_DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < PMTR_DEPTH; gi++) begin : g_word
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    mem_q[gi] <= PMTR_WORD_RST;
                end else if (wr_en && wr_addr == pmtr_addr_t'(gi)) begin
                    mem_q[gi] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= PMTR_WORD_RST;
        end else if (rd_en) begin
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule

// File: design/pmtr_top.sv
// Program memory access: fetch, table reads, high-byte latch, pin routing.
// Assumes the core holds a request until the done pulse and reads ports
// from its own clock domain; serial pins come from outside.
module pmtr_top
    import pmtr_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // Fetch
    input  wire logic                 fetch_adv,
    input  wire logic                 pc_load,
    input  wire pmtr_pkg::pmtr_addr_t pc_load_val,
    output pmtr_pkg::pmtr_addr_t      pc_q,
    output pmtr_pkg::pmtr_word_t      instr_q,
    // Table read request
    input  wire logic                 tr_req,
    input  wire pmtr_pkg::pmtr_op_e   tr_op,
    input  wire logic [1:0]           tr_dst_sector,
    input  wire logic [7:0]           tr_dst_addr,
    input  wire pmtr_pkg::pmtr_byte_t table_ptr_lo,
    input  wire pmtr_pkg::pmtr_byte_t table_ptr_hi,
    output logic                      tr_busy_q,
    output logic                      tr_done_q,
    output logic                      tr_illegal_q,
    output logic                      dst_we_q,
    output logic [1:0]                dst_sector_q,
    output logic [7:0]                dst_addr_q,
    output pmtr_pkg::pmtr_byte_t      dst_data_q,
    // High-byte latch access
    input  wire logic                 latch_we,
    input  wire pmtr_pkg::pmtr_byte_t latch_wdata,
    output pmtr_pkg::pmtr_byte_t      table_high_latch_q,
    // Store load from programming engine
    input  wire logic                 prog_wr,
    input  wire pmtr_pkg::pmtr_addr_t prog_addr,
    input  wire pmtr_pkg::pmtr_word_t prog_data,
    // Programming pins
    input  wire logic                 prog_mode,
    input  wire logic                 prog_serial_io_i,
    output logic                      prog_serial_io_o,
    output logic                      prog_serial_io_oe,
    input  wire logic                 prog_serial_clk,
    // Debug pins
    input  wire logic                 debug_mode,
    input  wire logic                 debug_serial_io_i,
    output logic                      debug_serial_io_o,
    output logic                      debug_serial_io_oe,
    input  wire logic                 debug_serial_clk,
    // Protocol engine side
    output logic                      eng_prog_data_q,
    output logic                      eng_prog_clk_q,
    output logic                      eng_dbg_data_q,
    output logic                      eng_dbg_clk_q,
    input  wire logic                 eng_prog_drive,
    input  wire logic                 eng_prog_out,
    input  wire logic                 eng_dbg_drive,
    input  wire logic                 eng_dbg_out,
    // Shared pin function (general I/O)
    input  wire logic                 gpio_drive,
    input  wire logic                 gpio_out,
    output logic                      gpio_in_q
);
    pmtr_state_e state_q;
    pmtr_addr_t  tr_addr_d;
    pmtr_addr_t  rd_addr;
    logic        rd_en;
    logic        tr_take;
    logic        op_short;
    logic        op_last;
    pmtr_word_t  rd_word;
    logic [3:0]  sy1_q;
    logic [3:0]  sy2_q;

    assign op_short = (tr_op == PMTR_TR_PAGED) || (tr_op == PMTR_TR_LASTPAGE);
    assign op_last  = (tr_op == PMTR_TR_LASTPAGE) ||
                      (tr_op == PMTR_TR_EXT_LASTPAGE);

    // only low nibble of high pointer
    always_comb begin
        if (op_last) begin
            tr_addr_d = PMTR_LAST_PAGE | {4'h0, table_ptr_lo};
        end else begin
            tr_addr_d = {table_ptr_hi[3:0], table_ptr_lo};
        end
    end

    assign tr_take = tr_req && (state_q == PMTR_ST_IDLE) &&
                     (!op_short || tr_dst_sector == PMTR_SECTOR0);

    // Table access wins the read port; fetch waits while busy
    assign rd_en   = tr_take || (state_q == PMTR_ST_RESET) ||
                     (fetch_adv && state_q == PMTR_ST_IDLE);
    assign rd_addr = tr_take ? tr_addr_d :
                     (state_q == PMTR_ST_RESET) ? PMTR_RESET_VEC : pc_q;

    // single store for code and data
    pmtr_store u_store (
        .clk     (clk),
        .resetn  (resetn),
        .wr_en   (prog_wr),
        .wr_addr (prog_addr),
        .wr_data (prog_data),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_data (rd_word)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= PMTR_ST_RESET;
        end else begin
            case (state_q)
                PMTR_ST_RESET: state_q <= PMTR_ST_IDLE;
                PMTR_ST_IDLE:  if (tr_take) state_q <= PMTR_ST_READ;
                PMTR_ST_READ:  state_q <= PMTR_ST_XFER;
                default:       state_q <= PMTR_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_q <= PMTR_RESET_VEC;
        end else if (state_q == PMTR_ST_RESET) begin
            pc_q <= PMTR_RESET_VEC + 12'h001;
        end else if (pc_load) begin
            pc_q <= pc_load_val;
        end else if (fetch_adv && state_q == PMTR_ST_IDLE && !tr_take) begin
            pc_q <= pc_q + 12'h001;
        end
    end

    logic fetch_pend_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetch_pend_q <= 1'b0;
        end else begin
            fetch_pend_q <= (state_q == PMTR_ST_RESET) ||
                            (fetch_adv && state_q == PMTR_ST_IDLE && !tr_take);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            instr_q <= PMTR_WORD_RST;
        end else if (fetch_pend_q) begin
            instr_q <= rd_word;
        end
    end

    // Request bookkeeping and destination transfer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tr_busy_q    <= 1'b0;
            tr_done_q    <= 1'b0;
            tr_illegal_q <= 1'b0;
            dst_we_q     <= 1'b0;
            dst_sector_q <= PMTR_SECTOR0;
            dst_addr_q   <= 8'h00;
            dst_data_q   <= PMTR_LATCH_RST;
        end else begin
            tr_done_q    <= 1'b0;
            dst_we_q     <= 1'b0;
            tr_illegal_q <= tr_req && state_q == PMTR_ST_IDLE && !tr_take;
            if (tr_take) begin
                tr_busy_q    <= 1'b1;
                dst_sector_q <= tr_dst_sector;
                dst_addr_q   <= tr_dst_addr;
            end else if (state_q == PMTR_ST_READ) begin
                dst_we_q   <= 1'b1;
                dst_data_q <= rd_word[7:0];
                tr_done_q  <= 1'b1;
                tr_busy_q  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            table_high_latch_q <= PMTR_LATCH_RST;
        end else if (state_q == PMTR_ST_READ) begin
            table_high_latch_q <= rd_word[15:8];
        end else if (latch_we) begin
            table_high_latch_q <= latch_wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sy1_q <= 4'h0;
            sy2_q <= 4'h0;
        end else begin
            sy1_q <= {prog_serial_io_i, prog_serial_clk,
                      debug_serial_io_i, debug_serial_clk};
            sy2_q <= sy1_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            eng_prog_data_q    <= 1'b0;
            eng_prog_clk_q     <= 1'b0;
            eng_dbg_data_q     <= 1'b0;
            eng_dbg_clk_q      <= 1'b0;
            gpio_in_q          <= 1'b0;
            prog_serial_io_o   <= 1'b0;
            prog_serial_io_oe  <= 1'b0;
            debug_serial_io_o  <= 1'b0;
            debug_serial_io_oe <= 1'b0;
        end else begin
            eng_prog_data_q    <= prog_mode  & sy2_q[3];
            eng_prog_clk_q     <= prog_mode  & sy2_q[2];
            eng_dbg_data_q     <= debug_mode & sy2_q[1];
            eng_dbg_clk_q      <= debug_mode & sy2_q[0];
            gpio_in_q          <= !debug_mode & sy2_q[1];
            prog_serial_io_o   <= eng_prog_out;
            prog_serial_io_oe  <= prog_mode & eng_prog_drive;
            if (debug_mode) begin
                debug_serial_io_o  <= eng_dbg_out;
                debug_serial_io_oe <= eng_dbg_drive;
            end else begin
                debug_serial_io_o  <= gpio_out;
                debug_serial_io_oe <= gpio_drive;
            end
        end
    end

    // Assertions
    property p_two_cycle;
        @(posedge clk) disable iff (!resetn)
        tr_take |=> tr_busy_q ##1 (tr_done_q && dst_we_q && !tr_busy_q);
    endproperty
    a_two_cycle: assert property (p_two_cycle)
        else $error("table read not done in two cycles");

    property p_sector;
        @(posedge clk) disable iff (!resetn)
        (tr_req && state_q == PMTR_ST_IDLE && op_short &&
         tr_dst_sector != PMTR_SECTOR0) |=> tr_illegal_q && !tr_busy_q;
    endproperty
    a_sector: assert property (p_sector)
        else $error("short form accepted outside sector 0");

    property p_lastpage;
        @(posedge clk) disable iff (!resetn)
        (tr_take && op_last) |-> rd_addr == (PMTR_LAST_PAGE |
                                              {4'h0, table_ptr_lo});
    endproperty
    a_lastpage: assert property (p_lastpage)
        else $error("last page address wrong");

    property p_paged;
        @(posedge clk) disable iff (!resetn)
        (tr_take && !op_last) |-> rd_addr == {table_ptr_hi[3:0], table_ptr_lo};
    endproperty
    a_paged: assert property (p_paged)
        else $error("paged address wrong");

    property p_split;
        @(posedge clk) disable iff (!resetn)
        (state_q == PMTR_ST_READ) |=>
            dst_data_q == $past(rd_word[7:0]) &&
            table_high_latch_q == $past(rd_word[15:8]);
    endproperty
    a_split: assert property (p_split)
        else $error("byte split wrong");

    property p_latch_wr;
        @(posedge clk) disable iff (!resetn)
        (latch_we && state_q != PMTR_ST_READ) |=>
            table_high_latch_q == $past(latch_wdata);
    endproperty
    a_latch_wr: assert property (p_latch_wr)
        else $error("latch write lost");

    property p_reset_fetch;
        @(posedge clk) disable iff (!resetn)
        (state_q == PMTR_ST_RESET) |-> rd_addr == PMTR_RESET_VEC;
    endproperty
    a_reset_fetch: assert property (p_reset_fetch)
        else $error("first fetch not at word zero");

    property p_dbg_block;
        @(posedge clk) disable iff (!resetn)
        debug_mode |=> !gpio_in_q && debug_serial_io_oe == $past(eng_dbg_drive);
    endproperty
    a_dbg_block: assert property (p_dbg_block)
        else $error("shared function active in debug");
endmodule

// File: sim/pmtr_core_model.sv
// Core-side model: issues table reads, fetches and latch writes.
// Assumes the block answers every request within 8 cycles.
module pmtr_core_model
    import pmtr_pkg::*;
(
    // Clock
    input  wire logic          clk,
    // Fetch
    output logic               fetch_adv,
    output logic               pc_load,
    output pmtr_pkg::pmtr_addr_t pc_load_val,
    // Table read
    output logic               tr_req,
    output pmtr_pkg::pmtr_op_e tr_op,
    output logic [1:0]         tr_dst_sector,
    output logic [7:0]         tr_dst_addr,
    output pmtr_pkg::pmtr_byte_t table_ptr_lo,
    output pmtr_pkg::pmtr_byte_t table_ptr_hi,
    input  wire logic          tr_done_q,
    input  wire logic          tr_illegal_q,
    // Latch write
    output logic               latch_we,
    output pmtr_pkg::pmtr_byte_t latch_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        {fetch_adv, pc_load, tr_req, latch_we} = 4'h0;
        {tr_dst_sector, tr_dst_addr} = 10'h000;
        {table_ptr_lo, table_ptr_hi, latch_wdata} = 24'h000000;
        pc_load_val = 12'h000;
        tr_op = PMTR_TR_PAGED;
    end

    // cycles counted from the taking edge
    task automatic table_read(input pmtr_op_e op, input logic [1:0] sec,
                              input logic [7:0] dst, input pmtr_byte_t lo,
                              input pmtr_byte_t hi, output logic ill,
                              output int cyc);
        int n;
        @(negedge clk);
        tr_req = 1'b1;
        tr_op = op;
        tr_dst_sector = sec;
        tr_dst_addr = dst;
        table_ptr_lo = lo;
        table_ptr_hi = hi;
        for (n = 1; n <= 8; n++) begin
            @(posedge clk);
            #1;
            if (tr_done_q === 1'b1 || tr_illegal_q === 1'b1)
                break;
        end
        ill = tr_illegal_q;
        cyc = n;
        @(negedge clk);
        // Released lines never keep the old value
        tr_req = 1'b0;
        tr_op = pmtr_op_e'(~op);
        tr_dst_sector = ~sec;
        tr_dst_addr = ~dst;
        table_ptr_lo = ~lo;
        table_ptr_hi = ~hi;
    endtask

    task automatic fetch_from(input pmtr_addr_t a);
        @(negedge clk);
        pc_load = 1'b1;
        pc_load_val = a;
        @(negedge clk);
        pc_load = 1'b0;
        pc_load_val = ~a;
        fetch_adv = 1'b1;
        @(negedge clk);
        fetch_adv = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic latch_write(input pmtr_byte_t v);
        @(negedge clk);
        latch_we = 1'b1;
        latch_wdata = v;
        @(negedge clk);
        latch_we = 1'b0;
        latch_wdata = ~v;
    endtask
endmodule

// File: sim/program_memory_table_read_tb.sv
// Self-checking bench: core model on requests, bench on serial pins.
// Assumes the store loads through the programming engine port.
module program_memory_table_read_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pmtr_pkg::*;

    logic clk, resetn, prog_wr, prog_mode, debug_mode, prog_serial_clk;
    logic debug_serial_clk, eng_prog_drive, eng_prog_out, eng_dbg_drive;
    logic eng_dbg_out, gpio_drive, gpio_out, tool_prog, tool_dbg;
    logic fetch_adv, pc_load, tr_req, tr_busy_q, tr_done_q, tr_illegal_q;
    logic dst_we_q, latch_we, prog_serial_io_o, prog_serial_io_oe;
    logic debug_serial_io_o, debug_serial_io_oe, eng_prog_data_q;
    logic eng_prog_clk_q, eng_dbg_data_q, eng_dbg_clk_q, gpio_in_q;
    logic [7:0] tr_dst_addr, dst_addr_q;
    logic [1:0] tr_dst_sector, dst_sector_q;
    pmtr_addr_t prog_addr, pc_load_val, pc_q;
    pmtr_word_t prog_data, instr_q;
    pmtr_byte_t table_ptr_lo, table_ptr_hi, latch_wdata, dst_data_q;
    pmtr_byte_t table_high_latch_q, exp_latch;
    pmtr_op_e tr_op;
    int error_cnt, tests_run, seed;
    // Pin level: device when enabled, else the outside tool
    wire logic prog_serial_io_i = prog_serial_io_oe ? prog_serial_io_o
                                                    : tool_prog;
    wire logic debug_serial_io_i = debug_serial_io_oe ? debug_serial_io_o
                                                      : tool_dbg;

    pmtr_top u_dut (.clk, .resetn, .fetch_adv, .pc_load, .pc_load_val,
        .pc_q, .instr_q, .tr_req, .tr_op, .tr_dst_sector, .tr_dst_addr,
        .table_ptr_lo, .table_ptr_hi, .tr_busy_q, .tr_done_q, .tr_illegal_q,
        .dst_we_q, .dst_sector_q, .dst_addr_q, .dst_data_q, .latch_we,
        .latch_wdata, .table_high_latch_q, .prog_wr, .prog_addr, .prog_data,
        .prog_mode, .prog_serial_io_i, .prog_serial_io_o, .prog_serial_io_oe,
        .prog_serial_clk, .debug_mode, .debug_serial_io_i,
        .debug_serial_io_o, .debug_serial_io_oe, .debug_serial_clk,
        .eng_prog_data_q, .eng_prog_clk_q, .eng_dbg_data_q, .eng_dbg_clk_q,
        .eng_prog_drive, .eng_prog_out, .eng_dbg_drive, .eng_dbg_out,
        .gpio_drive, .gpio_out, .gpio_in_q);

    pmtr_core_model u_core (.clk, .fetch_adv, .pc_load, .pc_load_val,
        .tr_req, .tr_op, .tr_dst_sector, .tr_dst_addr, .table_ptr_lo,
        .table_ptr_hi, .tr_done_q, .tr_illegal_q, .latch_we, .latch_wdata);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk_val(input string nm, input logic [15:0] e,
                           input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic chk_flag(input string nm, input logic e, input logic s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %b seen %b", nm, e, s);
        end
    endtask

    function automatic pmtr_addr_t exp_addr(pmtr_op_e op, pmtr_byte_t lo,
                                            pmtr_byte_t hi);
        if (op == PMTR_TR_LASTPAGE || op == PMTR_TR_EXT_LASTPAGE)
            return PMTR_LAST_PAGE | {4'h0, lo};
        return {hi[3:0], lo};
    endfunction

    task automatic load_word(input pmtr_addr_t a, input pmtr_word_t w);
        @(negedge clk);
        prog_wr = 1'b1;
        prog_addr = a;
        prog_data = w;
        @(negedge clk);
        prog_wr = 1'b0;
        prog_addr = ~a;
        prog_data = ~w;
    endtask

    task automatic do_reset();
        @(negedge clk);
        resetn = 1'b0;
        repeat (5) @(negedge clk);
        chk_val("pc_q", 16'(PMTR_RESET_VEC), 16'(pc_q));
        resetn = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk_val("pc_q", 16'(PMTR_RESET_VEC + 12'h001), 16'(pc_q));
        chk_val("instr_q", PMTR_WORD_RST, instr_q);
        exp_latch = PMTR_LATCH_RST;
    endtask

    task automatic tread(input pmtr_op_e op, input logic [1:0] sec,
                         input pmtr_byte_t lo, input pmtr_byte_t hi);
        pmtr_word_t w;
        logic [7:0] dst;
        logic ill, bad;
        int cyc;
        w = pmtr_word_t'($urandom);
        dst = 8'($urandom);
        bad = op inside {PMTR_TR_PAGED, PMTR_TR_LASTPAGE} &&
              sec != PMTR_SECTOR0;
        load_word(exp_addr(op, lo, hi), w);
        u_core.table_read(op, sec, dst, lo, hi, ill, cyc);
        if (cyc > 8) begin
            error_cnt++;
            $display("wrong value wait expected answer seen timeout");
            return;
        end
        chk_flag("tr_illegal_q", bad, ill);
        chk_flag("dst_we_q", !bad, dst_we_q);
        if (!bad) begin
            chk_val("cycles", 16'h0002, 16'(cyc));
            chk_val("dst_data_q", 16'(w[7:0]), 16'(dst_data_q));
            chk_val("dst", {6'h00, sec, dst},
                    {6'h00, dst_sector_q, dst_addr_q});
            exp_latch = w[15:8];
        end
        chk_val("latch", 16'(exp_latch), 16'(table_high_latch_q));
    endtask

    task automatic fetch_chk(input pmtr_addr_t a);
        pmtr_word_t w;
        w = pmtr_word_t'($urandom);
        load_word(a, w);
        u_core.fetch_from(a);
        chk_val("instr_q", w, instr_q);
        chk_val("pc_q", 16'(a + 12'h001), 16'(pc_q));
    endtask

    initial begin
        seed = $urandom(32'h3BD1);
        {resetn, prog_wr, prog_mode, debug_mode, prog_serial_clk} = 5'h00;
        {debug_serial_clk, eng_prog_drive, eng_prog_out} = 3'h0;
        {eng_dbg_drive, eng_dbg_out, gpio_drive, gpio_out} = 4'h0;
        {tool_prog, tool_dbg} = 2'h0;
        prog_addr = 12'h000;
        prog_data = 16'h0000;
        error_cnt = 0;
        tests_run = 0;
        do_reset();
        tread(PMTR_TR_LASTPAGE, 2'h0, 8'h03, 8'hA5);
        tread(PMTR_TR_PAGED, 2'h0, 8'hFF, 8'hFF);
        tread(PMTR_TR_EXT_PAGED, 2'h3, 8'h00, 8'hF0);
        tread(PMTR_TR_EXT_LASTPAGE, 2'h2, 8'hFF, 8'h00);
        for (int s = 1; s < 4; s++)
            tread(pmtr_op_e'(s[0]), 2'(s), 8'h10, 8'h01);
        u_core.latch_write(8'h5A);
        exp_latch = 8'h5A;
        chk_val("latch", 16'h005A, 16'(table_high_latch_q));
        tread(PMTR_TR_PAGED, 2'h1, 8'h20, 8'h02);
        repeat (16)
            tread(pmtr_op_e'($urandom_range(3)), 2'($urandom_range(3)),
                  8'($urandom), 8'($urandom));
        fetch_chk(PMTR_LAST_PAGE);
        fetch_chk(12'($urandom_range(4094)));
        prog_mode = 1'b1;
        eng_prog_drive = 1'b1;
        eng_prog_out = 1'b1;
        repeat (5) @(negedge clk);
        chk_flag("prog_oe", 1'b1, prog_serial_io_oe);
        chk_flag("prog_o", 1'b1, prog_serial_io_o);
        eng_prog_drive = 1'b0;
        tool_prog = 1'b1;
        prog_serial_clk = 1'b1;
        repeat (5) @(negedge clk);
        chk_flag("eng_prog_data", tool_prog, eng_prog_data_q);
        chk_flag("eng_prog_clk", 1'b1, eng_prog_clk_q);
        prog_mode = 1'b0;
        eng_prog_drive = 1'b1;
        {gpio_drive, gpio_out, tool_dbg, debug_serial_clk} = 4'hF;
        repeat (5) @(negedge clk);
        chk_flag("gpio_oe", 1'b1, debug_serial_io_oe);
        chk_flag("gpio_o", 1'b1, debug_serial_io_o);
        chk_flag("gpio_in_q", 1'b1, gpio_in_q);
        chk_flag("eng_dbg_data", 1'b0, eng_dbg_data_q);
        chk_flag("eng_dbg_clk", 1'b0, eng_dbg_clk_q);
        debug_mode = 1'b1;
        gpio_out = 1'b0;
        repeat (5) @(negedge clk);
        chk_flag("prog_oe", 1'b0, prog_serial_io_oe);
        chk_flag("debug_oe", 1'b0, debug_serial_io_oe);
        chk_flag("gpio_in_q", 1'b0, gpio_in_q);
        chk_flag("eng_dbg_data", 1'b1, eng_dbg_data_q);
        chk_flag("eng_dbg_clk", 1'b1, eng_dbg_clk_q);
        eng_dbg_drive = 1'b1;
        eng_dbg_out = 1'b1;
        repeat (5) @(negedge clk);
        chk_flag("debug_oe", 1'b1, debug_serial_io_oe);
        chk_flag("debug_o", 1'b1, debug_serial_io_o);
        chk_flag("gpio_in_q", 1'b0, gpio_in_q);
        do_reset();
        print_verdict();
    end
endmodule
